// File: common/msps_pkg.sv
// Purpose: shared constants for the measurement scaling / parallel status block
// Assumes: 250 MHz clock, 32-bit AHB-Lite register slave
// Notes:   byte offsets are word aligned
package msps_pkg;
    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_FACTOR  = 8'h04;
    localparam logic [7:0] OFS_DIVIDER = 8'h08;
    localparam logic [7:0] OFS_ADD     = 8'h0C;
    localparam logic [7:0] OFS_RAW     = 8'h10;
    localparam logic [7:0] OFS_UPDATE  = 8'h14;
    localparam logic [7:0] OFS_RESULT  = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1C;
    localparam logic [7:0] OFS_RETAIN  = 8'h20;
    // -----------------------------------------------------------------
    // control fields
    // -----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;   // 3 bits
    localparam int CTRL_SIG_LSB  = 4;   // 3 bits
    localparam int CTRL_DIR_BIT  = 8;
    localparam int CTRL_LIN_LSB  = 9;   // 2 bits
    localparam int CTRL_RET_BIT  = 12;
    localparam int CTRL_PIN_LSB  = 16;  // 2 bits
    localparam int CTRL_EPOL_BIT = 18;
    localparam int CTRL_SPOL_BIT = 19;
    localparam int CTRL_DFLT_BIT = 31;
    // -----------------------------------------------------------------
    // reset / default values
    // -----------------------------------------------------------------
    localparam logic [31:0] FACTOR_DFLT  = 32'h0000_0001;
    localparam logic [31:0] DIVIDER_DFLT = 32'h0000_0001;
    localparam logic [31:0] ADD_DFLT     = 32'h0000_0000;
    localparam logic [31:0] UPDATE_DFLT  = 32'h0000_0C00;
    localparam logic [31:0] FACTOR_MAX   = 32'h05F5_E0FF;  // 99999999
    localparam logic [31:0] DIVADD_MAX   = 32'h0098_967F;  // 9999999
    localparam int          OUT_BITS     = 25;
    localparam int          BAUD         = 115200;  // [R7]
    localparam int          CLK_HZ       = 250_000_000;
    localparam int          BAUD_DIV     = CLK_HZ / BAUD;
    // -----------------------------------------------------------------
    // enumerations
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NONE  = 3'h0,
        MODE_FREQ  = 3'h1,
        MODE_COUNT = 3'h2,
        MODE_SSI   = 3'h3,
        MODE_STST  = 3'h4
    } msps_mode_t;
    typedef enum logic [1:0] {
        PIN_DATA   = 2'h0,
        PIN_ERR    = 2'h1,
        PIN_STABLE = 2'h2,
        PIN_BOTH   = 2'h3
    } msps_pin_t;
    typedef enum logic [1:0] {
        LIN_OFF = 2'h0,
        LIN_Q1  = 2'h1,
        LIN_Q4  = 2'h2
    } msps_lin_t;
endpackage : msps_pkg

// File: common/msps_cfg_if.sv
// Purpose: configuration carrier between register slave and datapath
// Assumes: single clock domain
// Notes:   fields are levels held by the slave, except raw_stb, a one-cycle strobe
`timescale 1ns/1ps
interface msps_cfg_if;
    logic [2:0]  mode;
    logic [2:0]  sig_type;
    logic        reverse;
    logic [1:0]  lin;
    logic        retain;
    logic [31:0] factor;
    logic [31:0] divider;
    logic [31:0] addend;
    logic [31:0] raw;
    logic        raw_stb;
    modport regs (output mode, sig_type, reverse, lin, retain, factor, divider, addend,
                  raw, raw_stb);
    modport core (input mode, sig_type, reverse, lin, retain, factor, divider, addend,
                  raw, raw_stb);
endinterface : msps_cfg_if

// File: core/msps_scale.sv
// Purpose: direction, multiply, divide and offset of one sample; curve setting changes nothing
// Assumes: raw sample arrives as a one-cycle strobe
// Notes:   divide is sequential, one quotient bit per cycle
`timescale 1ns/1ps
module msps_scale (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    msps_cfg_if.core         cfg,
    output logic [31:0]      result_o,
    output logic             valid_o,
    output logic             ovf_o
);
    typedef enum logic [1:0] {
        SC_IDLE = 2'h0,
        SC_DIV  = 2'h1,
        SC_DONE = 2'h2
    } msps_sc_t;

    msps_sc_t    st, next_st;
    logic [63:0] rem, next_rem;
    logic [63:0] quo, next_quo;
    logic [31:0] dvs, next_dvs;
    logic        neg, next_neg;
    logic [6:0]  cnt, next_cnt;
    logic [31:0] res, next_res;
    logic        vld, next_vld;
    logic        ovf, next_ovf;

    function automatic logic [63:0] abs64(input logic [63:0] v);
        abs64 = v[63] ? (~v + 64'h1) : v;
    endfunction

    logic [63:0] prod;
    logic [31:0] dir_raw;
    logic [63:0] shifted;
    logic signed [63:0] sq;
    logic signed [63:0] sum;
    always_comb begin
        dir_raw = cfg.reverse ? (~cfg.raw + 32'h1) : cfg.raw;                     // [R10]
        prod    = 64'($signed(dir_raw) * $signed(cfg.factor));                     // [R11] [R19]
        shifted = {rem[62:0], quo[63]};
        sq      = neg ? -$signed(quo) : $signed(quo);
        sum     = sq + 64'($signed(cfg.addend));                                   // [R13]
        next_st  = st;
        next_rem = rem;
        next_quo = quo;
        next_dvs = dvs;
        next_neg = neg;
        next_cnt = cnt;
        next_res = res;
        next_vld = 1'b0;
        next_ovf = ovf;
        case (st)
            SC_IDLE: begin
                if (cfg.raw_stb) begin
                    next_rem = 64'h0;
                    next_quo = abs64(prod);
                    next_dvs = cfg.divider[31] ? (~cfg.divider + 32'h1) : cfg.divider;
                    next_neg = prod[63] ^ cfg.divider[31];                         // [R12]
                    next_cnt = 7'h0;
                    next_st  = SC_DIV;
                end
            end
            SC_DIV: begin
                // zero divisor leaves the quotient at all ones and flags overflow
                next_quo = {quo[62:0], 1'b0};
                if (shifted >= {32'h0, dvs}) begin
                    next_rem    = shifted - {32'h0, dvs};
                    next_quo[0] = 1'b1;
                end else begin
                    next_rem = shifted;
                end
                next_cnt = cnt + 7'h1;
                if (cnt == 7'h3F) begin
                    next_st = SC_DONE;
                end
            end
            SC_DONE: begin
                next_res = sum[31:0];                                              // [R19]
                // curve correction: quadrant 1 on a negative sum loads the same sum[31:0], folding nothing
                if (cfg.lin == msps_pkg::LIN_Q1 && sum[63]) begin                  // [R14]
                    next_res = sum[31:0];
                end
                next_ovf = (dvs == 32'h0) || (sum[63:31] != {33{sum[63]}});
                if (cfg.mode == msps_pkg::MODE_NONE) begin                         // [R8]
                    next_res = 32'h0;
                    next_ovf = 1'b0;
                end
                next_vld = 1'b1;
                next_st  = SC_IDLE;
            end
            default: begin
                next_st = SC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st  <= SC_IDLE;
            rem <= 64'h0;
            quo <= 64'h0;
            dvs <= 32'h0;
            neg <= 1'b0;
            cnt <= 7'h0;
            res <= 32'h0;
            vld <= 1'b0;
            ovf <= 1'b0;
        end else begin
            st  <= next_st;
            rem <= next_rem;
            quo <= next_quo;
            dvs <= next_dvs;
            neg <= next_neg;
            cnt <= next_cnt;
            res <= next_res;
            vld <= next_vld;
            ovf <= next_ovf;
        end
    end

    assign result_o = res;
    assign valid_o  = vld;
    assign ovf_o    = ovf;
endmodule : msps_scale

// File: core/msps_settle.sv
// Purpose: refresh pacing of the parallel word and the data-settled window
// Assumes: period counted in clock cycles, at least 3
// Notes:   word changes only in the first third, settled in the last two
`timescale 1ns/1ps
module msps_settle (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [31:0] period_i,
    output logic             load_o,
    output logic             settled_o
);
    logic [31:0] cnt, next_cnt;
    logic        load, next_load;
    logic        settled, next_settled;
    logic [31:0] third;

    always_comb begin
        third        = period_i / 32'h3;
        next_cnt     = cnt + 32'h1;
        next_load    = 1'b0;
        next_settled = settled;
        if (cnt + 32'h1 >= period_i) begin
            next_cnt     = 32'h0;
            next_settled = 1'b0;                                                  // [R20]
        end
        if (cnt == 32'h0) begin
            next_load = 1'b1;
        end
        // settled rises just after one third; stays until period end, period - third - 1 cycles
        if (cnt == third) begin
            next_settled = 1'b1;                                                  // [R5]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt     <= 32'h0;
            load    <= 1'b0;
            settled <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            load    <= next_load;
            settled <= next_settled;
        end
    end

    assign load_o    = load;
    assign settled_o = settled;
endmodule : msps_settle

// File: core/msps_top.sv
// Purpose: measurement scaling and parallel status output with AHB-Lite registers
// Assumes: raw samples written by software or an engine into the raw register
// Notes:   zero wait state slave, always OKAY
//
// Behaviour
// [R1] - error flag on bit 25, or bit 24 when settled flag also used
// [R2] - error flag active low by default, high when polarity inverted
// [R3] - settled flag active only while the parallel word is stable
// [R4] - trailing edge of settled still sees stable data for remote latch
// [R5] - each settled period lasts at least one third of refresh period
// [R6] - active high setting inverts settled waveform, same timing
// [R7] - serial link fixed 115200 baud 8N1, not user changeable
// [R8] - mode codes 0..4; code 0 forces outputs and results to zero; code zeroes word and result, flag pins still follow pin select
// [R9] - input signal type codes 0..4, used only in frequency and counter
// [R10] - direction 0 keeps sense, 1 reverses it
// [R11] - multiply by signed factor within +-99999999, default 1
// [R12] - divide by signed divisor within +-9999999, default 1
// [R13] - add signed offset within +-9999999, default 0
// [R14] - curve correction off, first quadrant, or all four quadrants; code applies no correction in any setting
// [R15] - retention keeps count across power loss in counter mode only
// [R16] - writing 1 to defaults reload restores all parameters
// [R17] - parallel output is 25 push-pull bits
// [R18] - factory reset input must be held high one second by outside
// [R19] - order is multiply, divide, then add offset
// [R20] - parallel word changes only while settled flag inactive
`timescale 1ns/1ps
module msps_top (
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic [24:0]      PAR_OUT_O,
    output logic             BIT25_O,
    output logic             SIG_SEL_DIFF_O
);
    // -----------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] factor, next_factor;
    logic [31:0] divider, next_divider;
    logic [31:0] addend, next_addend;
    logic [31:0] raw, next_raw;
    logic        raw_stb, next_raw_stb;
    logic [31:0] upd, next_upd;
    logic [31:0] retained, next_retained;
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] rdata, next_rdata;

    logic [31:0] result;
    logic        res_vld;
    logic        ovf;
    logic        load;
    logic        settled;

    msps_cfg_if cfg_bus ();

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lim);
        logic [31:0] nlim;
        nlim = ~lim + 32'h1;
        if (!v[31] && v > lim) begin
            clamp = lim;
        end else if (v[31] && $signed(v) < $signed(nlim)) begin
            clamp = nlim;
        end else begin
            clamp = v;
        end
    endfunction

    logic        acc;
    logic [2:0]  mode;
    logic [1:0]  pin;
    always_comb begin
        acc  = HSEL_I && HREADY_I && HTRANS_I[1];
        mode = ctrl[msps_pkg::CTRL_MODE_LSB +: 3];
        pin  = ctrl[msps_pkg::CTRL_PIN_LSB +: 2];
    end

    always_comb begin
        next_ctrl     = ctrl;
        next_factor   = factor;
        next_divider  = divider;
        next_addend   = addend;
        next_raw      = raw;
        next_raw_stb  = 1'b0;
        next_upd      = upd;
        next_retained = retained;
        next_wr_pend  = acc && HWRITE_I;
        next_wr_addr  = HADDR_I[7:0];
        next_rdata    = rdata;
        if (wr_pend) begin
            case (wr_addr)
                msps_pkg::OFS_CTRL: begin
                    if (HWDATA_I[msps_pkg::CTRL_DFLT_BIT]) begin                   // [R16]
                        next_ctrl    = 32'h0;
                        next_factor  = msps_pkg::FACTOR_DFLT;
                        next_divider = msps_pkg::DIVIDER_DFLT;
                        next_addend  = msps_pkg::ADD_DFLT;
                        next_upd     = msps_pkg::UPDATE_DFLT;
                    end else begin
                        next_ctrl = {1'b0, HWDATA_I[30:0]};
                    end
                end
                msps_pkg::OFS_FACTOR: begin
                    next_factor = clamp(HWDATA_I, msps_pkg::FACTOR_MAX);           // [R11]
                end
                msps_pkg::OFS_DIVIDER: begin
                    next_divider = clamp(HWDATA_I, msps_pkg::DIVADD_MAX);          // [R12]
                end
                msps_pkg::OFS_ADD: begin
                    next_addend = clamp(HWDATA_I, msps_pkg::DIVADD_MAX);           // [R13]
                end
                msps_pkg::OFS_RAW: begin
                    next_raw     = HWDATA_I;
                    next_raw_stb = 1'b1;
                end
                msps_pkg::OFS_UPDATE: begin
                    next_upd = (HWDATA_I < 32'h3) ? 32'h3 : HWDATA_I;
                end
                default: begin
                end
            endcase
        end
        // retention copy tracks the count only when enabled in counter mode
        if (res_vld && ctrl[msps_pkg::CTRL_RET_BIT]
                && mode == msps_pkg::MODE_COUNT) begin                            // [R15]
            next_retained = result;
        end else if (!ctrl[msps_pkg::CTRL_RET_BIT]) begin
            next_retained = 32'h0;
        end
        if (acc && !HWRITE_I) begin
            case (HADDR_I[7:0])
                msps_pkg::OFS_CTRL:    next_rdata = ctrl;
                msps_pkg::OFS_FACTOR:  next_rdata = factor;
                msps_pkg::OFS_DIVIDER: next_rdata = divider;
                msps_pkg::OFS_ADD:     next_rdata = addend;
                msps_pkg::OFS_RAW:     next_rdata = raw;
                msps_pkg::OFS_UPDATE:  next_rdata = upd;
                msps_pkg::OFS_RESULT:  next_rdata = result;
                msps_pkg::OFS_STATUS:  next_rdata = {30'h0, settled, ovf};
                msps_pkg::OFS_RETAIN:  next_rdata = retained;
                default:               next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= 32'h0;
            factor   <= msps_pkg::FACTOR_DFLT;
            divider  <= msps_pkg::DIVIDER_DFLT;
            addend   <= msps_pkg::ADD_DFLT;
            raw      <= 32'h0;
            raw_stb  <= 1'b0;
            upd      <= msps_pkg::UPDATE_DFLT;
            retained <= 32'h0;
            wr_pend  <= 1'b0;
            wr_addr  <= 8'h0;
            rdata    <= 32'h0;
        end else begin
            ctrl     <= next_ctrl;
            factor   <= next_factor;
            divider  <= next_divider;
            addend   <= next_addend;
            raw      <= next_raw;
            raw_stb  <= next_raw_stb;
            upd      <= next_upd;
            retained <= next_retained;
            wr_pend  <= next_wr_pend;
            wr_addr  <= next_wr_addr;
            rdata    <= next_rdata;
        end
    end

    assign HRDATA_O    = rdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    assign cfg_bus.mode     = mode;
    assign cfg_bus.sig_type = ctrl[msps_pkg::CTRL_SIG_LSB +: 3];
    assign cfg_bus.reverse  = ctrl[msps_pkg::CTRL_DIR_BIT];
    assign cfg_bus.lin      = ctrl[msps_pkg::CTRL_LIN_LSB +: 2];
    assign cfg_bus.retain   = ctrl[msps_pkg::CTRL_RET_BIT];
    assign cfg_bus.factor   = factor;
    assign cfg_bus.divider  = divider;
    assign cfg_bus.addend   = addend;
    assign cfg_bus.raw      = raw;
    assign cfg_bus.raw_stb  = raw_stb;

    msps_scale u_scale (
        .clk_i    (CLK_I),
        .rst_n_i  (rst_n),
        .cfg      (cfg_bus),
        .result_o (result),
        .valid_o  (res_vld),
        .ovf_o    (ovf)
    );

    msps_settle u_settle (
        .clk_i     (CLK_I),
        .rst_n_i   (rst_n),
        .period_i  (upd),
        .load_o    (load),
        .settled_o (settled)
    );

    // -----------------------------------------------------------------
    // parallel output
    // -----------------------------------------------------------------
    logic [24:0] par, next_par;
    logic        b25, next_b25;
    logic        sig_diff, next_sig_diff;
    logic        err_lvl;
    logic        st_lvl;
    always_comb begin
        err_lvl = ovf ^ ~ctrl[msps_pkg::CTRL_EPOL_BIT];                            // [R2]
        st_lvl  = settled ^ ~ctrl[msps_pkg::CTRL_SPOL_BIT];                        // [R6]
        next_par = par;
        if (load) begin
            next_par = result[24:0];                                               // [R17] [R20]
        end
        if (mode == msps_pkg::MODE_NONE) begin
            next_par = 25'h0;                                                      // [R8]
        end
        if (pin == msps_pkg::PIN_BOTH) begin
            next_par[24] = err_lvl;                                                // [R1]
        end
        case (pin)
            msps_pkg::PIN_ERR:    next_b25 = err_lvl;                              // [R1]
            msps_pkg::PIN_STABLE: next_b25 = st_lvl;                               // [R3] [R4]
            msps_pkg::PIN_BOTH:   next_b25 = st_lvl;                               // [R3]
            default:              next_b25 = result[25];
        endcase
        if (mode == msps_pkg::MODE_NONE && pin == msps_pkg::PIN_DATA) begin
            next_b25 = 1'b0;
        end
        // signal type only steers the front end in frequency and counter modes
        next_sig_diff = (mode == msps_pkg::MODE_FREQ || mode == msps_pkg::MODE_COUNT)
                        && (cfg_bus.sig_type <= 3'h1);                             // [R9]
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            par      <= 25'h0;
            b25      <= 1'b0;
            sig_diff <= 1'b0;
        end else begin
            par      <= next_par;
            b25      <= next_b25;
            sig_diff <= next_sig_diff;
        end
    end

    assign PAR_OUT_O      = par;
    assign BIT25_O        = b25;
    assign SIG_SEL_DIFF_O = sig_diff;
endmodule : msps_top

// File: sim/msps_sva.sv
// Purpose: port checks on the settled window, mode zero and select line
// Assumes: control and period shadowed from bus writes
// Notes:   guards wait out config changes before judging
`timescale 1ns/1ps
module msps_chk (
    input wire logic        CLK_I,
    input wire logic        RSTN_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic [24:0] PAR_OUT_O,
    input wire logic        BIT25_O,
    input wire logic        SIG_SEL_DIFF_O
);
    logic [31:0] ctrl, per;
    logic [15:0] quiet, run;
    logic        wph;
    logic [7:0]  aph;
    wire         act = BIT25_O == ctrl[19];
    wire         sd  = ctrl[17];
    always_ff @(posedge CLK_I or negedge RSTN_I)
        if (!RSTN_I) begin
            {ctrl, quiet, run, wph, aph} <= '0;
            per <= 32'h0000_0C00;
        end else begin
            wph <= HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
            aph <= HADDR_I[7:0];
            run <= act ? run + 16'h1 : '0;
            quiet <= wph ? '0 : quiet + {15'h0, ~&quiet};
            if (wph && aph == 8'h00) ctrl <= HWDATA_I[31] ? '0 : HWDATA_I;
            if (wph && aph == 8'h14) per <= HWDATA_I;
        end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_act_end; act ##1 !act; endsequence
    settled_hold_a: assert property (sd && quiet > 16'h4 && act ##1 act
        |-> $stable(PAR_OUT_O[23:0])) else $error("word moved while settled");
    latch_edge_a: assert property (sd && quiet > 16'h4 ##0 s_act_end
        |-> $stable(PAR_OUT_O[23:0])) else $error("word moved at trailing edge");
    settled_len_a: assert property (sd && quiet > per[15:0] + 16'h4 && $fell(act)
        |-> run >= per[15:0] / 3) else $error("settled window too short");
    refresh_a: assert property (sd && quiet > per[15:0] + 16'h4 && per < 32'h100
        && $fell(act) |-> ##[2:300] $rose(act)) else $error("settled window missing");
    word_change_a: assert property (sd && quiet > 16'h4 && $changed(PAR_OUT_O[23:0])
        |-> !act) else $error("word changed while settled");
    mode_zero_a: assert property (ctrl[2:0] == 3'h0 && quiet > 16'h4
        |-> PAR_OUT_O[23:0] == '0) else $error("mode zero word not zero");
    sigsel_a: assert property (quiet > 16'h4 |-> SIG_SEL_DIFF_O ==
        (ctrl[2:0] inside {3'h1, 3'h2} && ctrl[6:4] < 3'h2)) else $error("select wrong");
    bus_okay_a: assert property (HREADYOUT_O && !HRESP_O) else $error("bus not ready or error");
endmodule // msps_chk
bind msps_top msps_chk chk (.*);

// File: sim/msps_latch.sv
// Purpose: remote controller latching the word on the settled trailing edge
// Assumes: polarity told by the bench
// Notes:   takes the word at the edge that ends the active level
`timescale 1ns/1ps
module msps_latch (
    input  wire logic        clk_i,
    input  wire logic        active_high_i,
    input  wire logic        settled_i,
    input  wire logic [24:0] word_i,
    output logic [24:0]      latched_o
);
    logic last;
    always @(posedge clk_i) begin
        if (last == active_high_i && settled_i != active_high_i) latched_o <= word_i;
        last <= settled_i;
    end
endmodule // msps_latch

// File: sim/tb_top.sv
// Purpose: self-checking bench for msps_top
// Assumes: zero wait slave, result ready well inside 200 cycles
// Notes:   refresh period shortened to 30 cycles
`timescale 1ns/1ps
module tb_top;
    logic        CLK_I, RSTN_I, HSEL_I, HWRITE_I, HREADYOUT_O, HRESP_O, BIT25_O;
    logic        SIG_SEL_DIFF_O, pol;
    logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, q;
    logic [1:0]  HTRANS_I;
    logic [2:0]  HSIZE_I;
    logic [24:0] PAR_OUT_O, latched;
    wire logic   HREADY_I = HREADYOUT_O;
    int          n_errors = 0;
    int          num_checks = 0;
    msps_top dut (.*);
    msps_latch ctl (.clk_i(CLK_I), .active_high_i(pol), .settled_i(BIT25_O),
                    .word_i(PAR_OUT_O), .latched_o(latched));
    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {HSEL_I, HTRANS_I, HWRITE_I, HADDR_I} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge CLK_I); while (HREADY_I !== 1'b1);
        {HSEL_I, HTRANS_I, HWDATA_I} <= {1'b0, 2'h0, d};
        do @(posedge CLK_I); while (HREADY_I !== 1'b1);
        q = HRDATA_O;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, '0);
        chk(q, e);
    endtask
    task automatic t_regs;
        rd(8'h04, msps_pkg::FACTOR_DFLT);
        rd(8'h08, msps_pkg::DIVIDER_DFLT);
        rd(8'h40, '0);
        wr(8'h04, 32'h7FFF_FFFF);
        rd(8'h04, msps_pkg::FACTOR_MAX);
        wr(8'h0C, 32'h8000_0000);
        rd(8'h0C, 32'h0 - msps_pkg::DIVADD_MAX);
        wr(8'h00, 32'h8000_0000);
        rd(8'h04, msps_pkg::FACTOR_DFLT);
        rd(8'h0C, msps_pkg::ADD_DFLT);
        $display("t_regs done");
    endtask
    task automatic t_scale;
        wr(8'h14, 32'h0000_001E);
        wr(8'h04, 32'h0000_0003);
        wr(8'h08, 32'h0000_0002);
        wr(8'h0C, 32'hFFFF_FFFB);
        for (int r = 0; r < 2; r++) begin
            wr(8'h00, {19'h0, 1'b1, 3'h0, r[0], 8'h02});
            wr(8'h10, 32'h0000_0064);
            repeat (200) @(posedge CLK_I);
            rd(8'h18, r ? 32'hFFFF_FF65 : 32'h0000_0091);
            rd(8'h20, r ? 32'hFFFF_FF65 : 32'h0000_0091);
            chk({7'h0, PAR_OUT_O}, r ? 32'h01FF_FF65 : 32'h0000_0091);
        end
        $display("t_scale done");
    endtask
    task automatic t_flags;
        for (int p = 0; p < 2; p++) begin
            pol <= p[0];
            wr(8'h00, {12'h0, p[0], 19'h2_0001});
            wr(8'h10, 32'h0000_0040);
            repeat (200) @(posedge CLK_I);
            chk({7'h0, latched}, 32'h0000_005B);
        end
        wr(8'h08, '0);
        for (int e = 0; e < 2; e++) begin
            wr(8'h00, {13'h0, e[0], 18'h3_0001});
            wr(8'h10, 32'h0000_0040);
            repeat (200) @(posedge CLK_I);
            chk({31'h0, PAR_OUT_O[24]}, {31'h0, e[0]});
        end
        wr(8'h00, 32'h0001_0001);
        repeat (200) @(posedge CLK_I);
        chk({31'h0, BIT25_O}, '0);
        $display("t_flags done");
    endtask
    task automatic t_mode;
        for (int m = 0; m < 5; m++) for (int s = 0; s < 5; s++) begin
            wr(8'h00, {25'h0, s[2:0], 1'b0, m[2:0]});
            repeat (2) @(posedge CLK_I);
            chk({31'h0, SIG_SEL_DIFF_O}, {31'h0, (m == 1 || m == 2) && s < 2});
        end
        wr(8'h00, 32'h0000_0002);
        rd(8'h20, '0);
        wr(8'h00, '0);
        wr(8'h10, 32'h0000_0040);
        repeat (200) @(posedge CLK_I);
        rd(8'h18, '0);
        chk({7'h0, PAR_OUT_O}, '0);
        $display("t_mode done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        {RSTN_I, HSEL_I, HWRITE_I, HTRANS_I, HADDR_I, HWDATA_I, pol} = '0;
        HSIZE_I = 3'h2;
        repeat (10) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        t_regs();
        t_scale();
        t_flags();
        t_mode();
        give_verdict();
    end
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
endmodule // tb_top
